// *** design/sdee_pkg.sv ***
// Constants shared by the emergency encoder design files
package sdee_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SDEE_OFF_CTRL     = 8'h00;
	localparam logic [7:0] SDEE_OFF_MODIDX   = 8'h04;
	localparam logic [7:0] SDEE_OFF_ERRCODE  = 8'h08;
	localparam logic [7:0] SDEE_OFF_STATUS   = 8'h0c;
	localparam logic [7:0] SDEE_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] SDEE_OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] SDEE_OFF_SIO_WORD = 8'h18;
	localparam logic [7:0] SDEE_OFF_GW_WORD  = 8'h1c;
	localparam logic [7:0] SDEE_OFF_LAST     = 8'h20;
	localparam logic [7:0] SDEE_OFF_COUNT    = 8'h24;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SDEE_CTRL_EN      = 0;
	localparam int SDEE_CTRL_FORCE   = 1;
	localparam int SDEE_CTRL_NODE_LO = 8;
	localparam int SDEE_CTRL_NODE_HI = 14;
	localparam int SDEE_IRQ_SENT     = 0;
	localparam int SDEE_IRQ_SIO      = 1;
	localparam int SDEE_IRQ_GW       = 2;
	localparam int SDEE_IRQ_OVR      = 3;
	localparam int SDEE_IRQ_W        = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] SDEE_RST_CTRL    = 32'h0000_0000;
	localparam logic [7:0]  SDEE_RST_MODIDX  = 8'h00;
	localparam logic [15:0] SDEE_RST_ERRCODE = 16'h7001;
	localparam logic [7:0]  SDEE_RST_ERRREG  = 8'h00;

	// ------------------------------------------------------------
	// Frame constants
	// ------------------------------------------------------------
	localparam logic [10:0] SDEE_EMCY_BASE = 11'h080;
	localparam logic [3:0]  SDEE_EMCY_DLC  = 4'h8;
	localparam logic [3:0]  SDEE_ID_SIO    = 4'h2;
	localparam logic [3:0]  SDEE_ID_GW     = 4'h3;

	// ------------------------------------------------------------
	// State bit positions, safe input/output module
	// ------------------------------------------------------------
	localparam int SDEE_SIO_INT     = 1;
	localparam int SDEE_SIO_EXT     = 2;
	localparam int SDEE_SIO_HIST    = 3;
	localparam int SDEE_SIO_CFG     = 4;
	localparam int SDEE_SIO_SUPPLY  = 5;
	localparam int SDEE_SIO_DUAL    = 8;
	localparam int SDEE_SIO_IN_ST   = 14;
	localparam int SDEE_SIO_OUT_ST  = 15;
	localparam int SDEE_SIO_TEST    = 16;
	localparam int SDEE_SIO_SHORT   = 24;

	// ------------------------------------------------------------
	// State bit positions, gateway module
	// ------------------------------------------------------------
	localparam int SDEE_GW_INT    = 1;
	localparam int SDEE_GW_CFG    = 4;
	localparam int SDEE_GW_IN_ST  = 5;
	localparam int SDEE_GW_OUT_ST = 6;

	// ------------------------------------------------------------
	// Frame sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SDEE_IDLE = 2'b01,
		SDEE_SEND = 2'b10
	} sdee_state_t;

endpackage

// *** design/sdee_map.sv ***
// Maps module diagnostic conditions onto 32-bit emergency state words
`timescale 1ns/1ps
module sdee_map
	import sdee_pkg::*;
(
	input  wire logic        sio_internal_fail,
	input  wire logic        sio_external_fail,
	input  wire logic        sio_history,
	input  wire logic        sio_config_bad,
	input  wire logic        sio_supply_bad,
	input  wire logic [3:0]  sio_dual_err,
	input  wire logic        sio_in_state,
	input  wire logic        sio_out_state,
	input  wire logic [7:0]  sio_test_err,
	input  wire logic [3:0]  sio_short_high,
	input  wire logic [3:0]  sio_short_low,
	input  wire logic        gw_internal_fail,
	input  wire logic        gw_config_bad,
	input  wire logic        gw_in_state,
	input  wire logic        gw_out_state,
	output logic      [31:0] sio_word,
	output logic      [31:0] gw_word
);

	// ------------------------------------------------------------
	// Safe input/output word, reserved bits stay zero
	// ------------------------------------------------------------
	always_comb begin
		sio_word = 32'h0000_0000;
		sio_word[SDEE_SIO_INT]    = sio_internal_fail;
		sio_word[SDEE_SIO_EXT]    = sio_external_fail;
		sio_word[SDEE_SIO_HIST]   = sio_history;
		sio_word[SDEE_SIO_CFG]    = sio_config_bad;
		sio_word[SDEE_SIO_SUPPLY] = sio_supply_bad;
		sio_word[SDEE_SIO_IN_ST]  = sio_in_state;
		sio_word[SDEE_SIO_OUT_ST] = sio_out_state;
		for (int i = 0; i < 4; i++) begin
			sio_word[SDEE_SIO_DUAL + i] = sio_dual_err[i];
			sio_word[SDEE_SIO_SHORT + 2*i] = sio_short_high[i];
			sio_word[SDEE_SIO_SHORT + 2*i + 1] = sio_short_low[i];
		end
		for (int i = 0; i < 8; i++) begin
			sio_word[SDEE_SIO_TEST + i] = sio_test_err[i];
		end
	end

	// ------------------------------------------------------------
	// Gateway word, bits 0, 2, 3 and 7 up reserved
	// ------------------------------------------------------------
	always_comb begin
		gw_word = 32'h0000_0000;
		gw_word[SDEE_GW_INT]    = gw_internal_fail;
		gw_word[SDEE_GW_CFG]    = gw_config_bad;
		gw_word[SDEE_GW_IN_ST]  = gw_in_state;
		gw_word[SDEE_GW_OUT_ST] = gw_out_state;
	end

endmodule

// *** design/sdee_top.sv ***
// Emergency frame encoder with APB registers and interrupt
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module sdee_top
	import sdee_pkg::*;
#(
	parameter int NODE_W = 7
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sio_internal_fail,
	input  wire logic        sio_external_fail,
	input  wire logic        sio_history,
	input  wire logic        sio_config_bad,
	input  wire logic        sio_supply_bad,
	input  wire logic [3:0]  sio_dual_err,
	input  wire logic        sio_in_state,
	input  wire logic        sio_out_state,
	input  wire logic [7:0]  sio_test_err,
	input  wire logic [3:0]  sio_short_high,
	input  wire logic [3:0]  sio_short_low,
	input  wire logic        gw_internal_fail,
	input  wire logic        gw_config_bad,
	input  wire logic        gw_in_state,
	input  wire logic        gw_out_state,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [10:0] tx_id,
	output logic      [3:0]  tx_dlc,
	output logic      [63:0] tx_data,
	output logic             irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [31:0]        sio_word;
	logic [31:0]        gw_word;
	logic               en_r;
	logic               force_r;
	logic [NODE_W-1:0]  node_r;
	logic [3:0]         sio_idx_r;
	logic [3:0]         gw_idx_r;
	logic [15:0]        err_code_r;
	logic [7:0]         err_reg_r;
	logic [SDEE_IRQ_W-1:0] irq_stat_r;
	logic [SDEE_IRQ_W-1:0] irq_mask_r;
	logic [SDEE_IRQ_W-1:0] irq_set;
	logic [SDEE_IRQ_W-1:0] irq_clr;
	logic [31:0]        sio_sent_r;
	logic [31:0]        gw_sent_r;
	logic [31:0]        last_word_r;
	logic [15:0]        count_r;
	logic               pready_r;
	logic               pslverr_r;
	logic [31:0]        prdata_r;
	logic               tx_valid_r;
	logic [10:0]        tx_id_r;
	logic [3:0]         tx_dlc_r;
	logic [63:0]        tx_data_r;
	logic               irq_r;
	sdee_state_t        state_r;
	sdee_state_t        state_nxt;
	logic               apb_done;
	logic               apb_wr;
	logic               sio_chg;
	logic               gw_chg;
	logic               launch;
	logic               pick_sio;
	logic               tx_done;
	logic [31:0]        rd_val;
	logic               rd_ok;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Emergency identifier from node address
	function automatic logic [10:0] emcy_id(input logic [NODE_W-1:0] n);
		emcy_id = SDEE_EMCY_BASE + 11'(n);
	endfunction

	// Eight data bytes, lowest byte first on the wire
	function automatic logic [63:0] emcy_data(
		input logic [15:0] code,
		input logic [7:0]  ereg,
		input logic [3:0]  did,
		input logic [3:0]  midx,
		input logic [31:0] word
	);
		emcy_data = {word, did, midx, ereg, code};
	endfunction

	// ------------------------------------------------------------
	// Diagnostic bit mapping
	// ------------------------------------------------------------
	sdee_map u_map (
		.sio_internal_fail (sio_internal_fail),
		.sio_external_fail (sio_external_fail),
		.sio_history       (sio_history),
		.sio_config_bad    (sio_config_bad),
		.sio_supply_bad    (sio_supply_bad),
		.sio_dual_err      (sio_dual_err),
		.sio_in_state      (sio_in_state),
		.sio_out_state     (sio_out_state),
		.sio_test_err      (sio_test_err),
		.sio_short_high    (sio_short_high),
		.sio_short_low     (sio_short_low),
		.gw_internal_fail  (gw_internal_fail),
		.gw_config_bad     (gw_config_bad),
		.gw_in_state       (gw_in_state),
		.gw_out_state      (gw_out_state),
		.sio_word          (sio_word),
		.gw_word           (gw_word)
	);

	// ------------------------------------------------------------
	// Change detection and sequencing
	// ------------------------------------------------------------
	// A word that differs from the one last sent wants a frame
	assign sio_chg  = en_r && ((sio_word != sio_sent_r) || force_r);
	assign gw_chg   = en_r && (gw_word != gw_sent_r);
	assign pick_sio = sio_chg;
	assign launch   = (state_r == SDEE_IDLE) && (sio_chg || gw_chg);
	assign tx_done  = (state_r == SDEE_SEND) && tx_valid_r && tx_ready;

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SDEE_IDLE: begin
				if (launch) begin
					state_nxt = SDEE_SEND;
				end
			end
			SDEE_SEND: begin
				if (tx_done) begin
					state_nxt = SDEE_IDLE;
				end
			end
			default: begin
				state_nxt = SDEE_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= SDEE_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Frame builder, held stable while waiting for the controller
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid_r <= 1'b0;
			tx_id_r    <= 11'h000;
			tx_dlc_r   <= 4'h0;
			tx_data_r  <= 64'h0;
		end else if (launch) begin
			tx_valid_r <= 1'b1;
			tx_id_r    <= emcy_id(node_r);
			tx_dlc_r   <= SDEE_EMCY_DLC;
			if (pick_sio) begin
				tx_data_r <= emcy_data(err_code_r, err_reg_r,
					SDEE_ID_SIO, sio_idx_r, sio_word);
			end else begin
				tx_data_r <= emcy_data(err_code_r, err_reg_r,
					SDEE_ID_GW, gw_idx_r, gw_word);
			end
		end else if (tx_done) begin
			tx_valid_r <= 1'b0;
		end
	end

	// Words last reported per module
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sio_sent_r  <= 32'h0000_0000;
			gw_sent_r   <= 32'h0000_0000;
			last_word_r <= 32'h0000_0000;
		end else if (launch) begin
			if (pick_sio) begin
				sio_sent_r  <= sio_word;
				last_word_r <= sio_word;
			end else begin
				gw_sent_r   <= gw_word;
				last_word_r <= gw_word;
			end
		end
	end

	// Frames handed to the controller
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= 16'h0000;
		end else if (tx_done) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// APB slave, one wait state per access
	// ------------------------------------------------------------
	assign apb_done = psel && penable && pready_r;
	assign apb_wr   = apb_done && pwrite && !pslverr_r;

	// Read mux and address decode
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (paddr)
			SDEE_OFF_CTRL: begin
				rd_val[SDEE_CTRL_EN] = en_r;
				rd_val[SDEE_CTRL_NODE_HI:SDEE_CTRL_NODE_LO] = node_r;
			end
			SDEE_OFF_MODIDX: begin
				rd_val[7:0] = {gw_idx_r, sio_idx_r};
			end
			SDEE_OFF_ERRCODE: begin
				rd_val[23:0] = {err_reg_r, err_code_r};
			end
			SDEE_OFF_STATUS: begin
				rd_val[2:0] = {gw_chg, sio_chg, tx_valid_r};
			end
			SDEE_OFF_IRQ_STAT: begin
				rd_val[SDEE_IRQ_W-1:0] = irq_stat_r;
			end
			SDEE_OFF_IRQ_MASK: begin
				rd_val[SDEE_IRQ_W-1:0] = irq_mask_r;
			end
			SDEE_OFF_SIO_WORD: begin
				rd_val = sio_word;
			end
			SDEE_OFF_GW_WORD: begin
				rd_val = gw_word;
			end
			SDEE_OFF_LAST: begin
				rd_val = last_word_r;
			end
			SDEE_OFF_COUNT: begin
				rd_val[15:0] = count_r;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// Ready, error and read data land together in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (psel && penable && !pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= !rd_ok;
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end
	end

	// Control and configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r       <= SDEE_RST_CTRL[SDEE_CTRL_EN];
			node_r     <= SDEE_RST_CTRL[SDEE_CTRL_NODE_HI:SDEE_CTRL_NODE_LO];
			sio_idx_r  <= SDEE_RST_MODIDX[3:0];
			gw_idx_r   <= SDEE_RST_MODIDX[7:4];
			err_code_r <= SDEE_RST_ERRCODE;
			err_reg_r  <= SDEE_RST_ERRREG;
		end else if (apb_wr) begin
			case (paddr)
				SDEE_OFF_CTRL: begin
					en_r   <= pwdata[SDEE_CTRL_EN];
					node_r <= pwdata[SDEE_CTRL_NODE_HI:SDEE_CTRL_NODE_LO];
				end
				SDEE_OFF_MODIDX: begin
					sio_idx_r <= pwdata[3:0];
					gw_idx_r  <= pwdata[7:4];
				end
				SDEE_OFF_ERRCODE: begin
					err_code_r <= pwdata[15:0];
					err_reg_r  <= pwdata[23:16];
				end
				default: begin
				end
			endcase
		end
	end

	// Forced resend of the safe module word, dropped once launched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_r <= 1'b0;
		end else if (apb_wr && (paddr == SDEE_OFF_CTRL)
				&& pwdata[SDEE_CTRL_FORCE]) begin
			force_r <= 1'b1;
		end else if (launch && pick_sio) begin
			force_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Events: frame sent, new change per module, change while busy
	always_comb begin
		irq_set = '0;
		irq_set[SDEE_IRQ_SENT] = tx_done;
		irq_set[SDEE_IRQ_SIO]  = launch && pick_sio;
		irq_set[SDEE_IRQ_GW]   = launch && !pick_sio;
		irq_set[SDEE_IRQ_OVR]  = (state_r == SDEE_SEND)
			&& ((sio_word != sio_sent_r) || (gw_word != gw_sent_r))
			&& en_r;
		irq_clr = '0;
		if (apb_wr && (paddr == SDEE_OFF_IRQ_STAT)) begin
			irq_clr = pwdata[SDEE_IRQ_W-1:0];
		end
	end

	// Sticky status, a new event outweighs a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= '0;
		end else if (apb_wr && (paddr == SDEE_OFF_IRQ_MASK)) begin
			irq_mask_r <= pwdata[SDEE_IRQ_W-1:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign tx_valid = tx_valid_r;
	assign tx_id    = tx_id_r;
	assign tx_dlc   = tx_dlc_r;
	assign tx_data  = tx_data_r;
	assign irq      = irq_r;

endmodule

// *** dv/sdee_monitor.sv ***
// Port checker for the emergency frame encoder
`timescale 1ns/1ps
module sdee_monitor
	import sdee_pkg::*;
#(
	parameter int NODE_W = 7
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sio_internal_fail,
	input wire logic        sio_external_fail,
	input wire logic        sio_history,
	input wire logic        sio_config_bad,
	input wire logic        sio_supply_bad,
	input wire logic [3:0]  sio_dual_err,
	input wire logic        sio_in_state,
	input wire logic        sio_out_state,
	input wire logic [7:0]  sio_test_err,
	input wire logic [3:0]  sio_short_high,
	input wire logic [3:0]  sio_short_low,
	input wire logic        gw_internal_fail,
	input wire logic        gw_config_bad,
	input wire logic        gw_in_state,
	input wire logic        gw_out_state,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [10:0] tx_id,
	input wire logic [3:0]  tx_dlc,
	input wire logic [63:0] tx_data
);
	logic [31:0] sio_exp;
	logic [31:0] gw_exp;
	logic        sio_f;
	logic        gw_f;
	// Expected state words built from the live conditions
	assign sio_exp = {sio_short_low[3], sio_short_high[3], sio_short_low[2],
		sio_short_high[2], sio_short_low[1], sio_short_high[1],
		sio_short_low[0], sio_short_high[0], sio_test_err, sio_out_state,
		sio_in_state, 2'b00, sio_dual_err, 2'b00, sio_supply_bad,
		sio_config_bad, sio_history, sio_external_fail, sio_internal_fail,
		1'b0};
	assign gw_exp = {25'h0, gw_out_state, gw_in_state, gw_config_bad, 2'b00,
		gw_internal_fail, 1'b0};
	assign sio_f = tx_valid && tx_data[31:28] == SDEE_ID_SIO;
	assign gw_f = tx_valid && tx_data[31:28] == SDEE_ID_GW;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	id_base_a: assert property (tx_valid |->
		(tx_id >> NODE_W) == (SDEE_EMCY_BASE >> NODE_W)) else $error("bad id");
	dlc_eight_a: assert property (tx_valid |-> tx_dlc == 4'h8)
		else $error("frame length not eight");
	diag_id_a: assert property (tx_valid |-> sio_f || gw_f)
		else $error("unknown diagnostics id");
	frame_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
		$stable(tx_data) && $stable(tx_id)) else $error("frame moved");
	sio_map_a:
		assert property ($rose(tx_valid) && sio_f |->
		tx_data[63:32] == $past(sio_exp)) else $error("safe word wrong");
	gw_map_a:
		assert property ($rose(tx_valid) && gw_f |->
		tx_data[63:32] == $past(gw_exp)) else $error("gateway word wrong");
	frame_drop_a: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("frame not released");
	apb_wait_a: assert property (penable && !pready |=> pready)
		else $error("no answer after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");

	sio_frame_c: cover property ($rose(tx_valid) && sio_f);
	gw_frame_c: cover property ($rose(tx_valid) && gw_f);
	stall_c: cover property (tx_valid && !tx_ready [*3]);
	slverr_c: cover property (pslverr);
endmodule

bind sdee_top sdee_monitor #(.NODE_W(NODE_W)) u_mon (
	.pclk, .presetn, .penable, .pready, .pslverr, .sio_internal_fail,
	.sio_external_fail, .sio_history, .sio_config_bad, .sio_supply_bad,
	.sio_dual_err, .sio_in_state, .sio_out_state, .sio_test_err,
	.sio_short_high, .sio_short_low, .gw_internal_fail, .gw_config_bad,
	.gw_in_state, .gw_out_state, .tx_valid, .tx_ready, .tx_id, .tx_dlc,
	.tx_data
);

// *** dv/sdee_can_master.sv ***
// CAN controller model that takes emergency frames with a set stall
`timescale 1ns/1ps
module sdee_can_master
	import sdee_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [3:0]  stall,
	input  wire logic        tx_valid,
	input  wire logic [10:0] tx_id,
	input  wire logic [3:0]  tx_dlc,
	input  wire logic [63:0] tx_data,
	output logic             tx_ready,
	output logic      [15:0] rx_cnt,
	output logic      [78:0] rx_frame,
	output logic             wire_chk
);
	logic [3:0] wait_r;
	// Ready only after the stall count, dropped after each take
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r <= 4'h0;
			tx_ready <= 1'b0;
		end else if (tx_valid && tx_ready) begin
			wait_r <= 4'h0;
			tx_ready <= 1'b0;
		end else if (tx_valid) begin
			wait_r <= wait_r + 4'h1;
			tx_ready <= wait_r >= stall;
		end
	end
	// Frame capture at the taking edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt <= 16'h0;
			rx_frame <= '0;
			wire_chk <= 1'b0;
		end else if (tx_valid && tx_ready) begin
			rx_cnt <= rx_cnt + 16'h1;
			rx_frame <= {tx_id, tx_dlc, tx_data};
			wire_chk <= sio_f_test(tx_data);
		end
	end
	// Input test fault seen: wiring to be inspected
	function automatic logic sio_f_test(logic [63:0] d);
		return d[31:28] == SDEE_ID_SIO && |d[55:48];
	endfunction
endmodule

// *** dv/sdee_top_tb.sv ***
// Self-checking bench for the emergency frame encoder
`timescale 1ns/1ps
module sdee_top_tb;
	import sdee_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] sw = 32'h0;
	logic [31:0] gw = 32'h0;
	logic [3:0]  stall = 4'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, tx_valid, tx_ready, irq, wchk;
	logic [10:0] tx_id;
	logic [3:0]  tx_dlc;
	logic [63:0] tx_data;
	logic [15:0] rx_cnt;
	logic [15:0] nfr = 16'h0;
	logic [78:0] rx_frame;
	int          err_count = 0;
	int          total_checks = 0;

	// Clock
	always #2.5 pclk = ~pclk;

	// Conditions drawn from the expected word layout
	sdee_top dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data,
		.irq, .sio_internal_fail(sw[1]), .sio_external_fail(sw[2]),
		.sio_history(sw[3]), .sio_config_bad(sw[4]), .sio_supply_bad(sw[5]),
		.sio_dual_err(sw[11:8]), .sio_in_state(sw[14]),
		.sio_out_state(sw[15]), .sio_test_err(sw[23:16]),
		.sio_short_high({sw[30], sw[28], sw[26], sw[24]}),
		.sio_short_low({sw[31], sw[29], sw[27], sw[25]}),
		.gw_internal_fail(gw[1]), .gw_config_bad(gw[4]),
		.gw_in_state(gw[5]), .gw_out_state(gw[6])
	);
	sdee_can_master can (
		.pclk, .presetn, .stall, .tx_valid, .tx_id, .tx_dlc, .tx_data,
		.tx_ready, .rx_cnt, .rx_frame, .wire_chk(wchk)
	);

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(string nm, logic [78:0] e, logic [78:0] g);
		total_checks++;
		if (e !== g) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// APB transfer held until ready, then one idle cycle
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) begin
				err_count++;
				stop_test();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Waits for the next taken frame and compares it whole
	task automatic frame(logic [31:0] w, logic [3:0] id, logic [3:0] mi);
		int          n;
		logic [78:0] e;
		n = 0;
		nfr++;
		e = {SDEE_EMCY_BASE + 11'h23, 4'h8, w, id, mi, 24'h5a7001};
		while (rx_cnt !== nfr) begin
			@(posedge pclk);
			n++;
			if (n > 80) begin
				err_count++;
				stop_test();
			end
		end
		chk("frame", e, rx_frame);
		chk("wiring", (id == SDEE_ID_SIO) && |w[23:16], wchk);
	endtask

	// A pending change must not leave while the block is off
	task automatic t_regs();
		sw <= 32'h2;
		apb(1'b0, SDEE_OFF_ERRCODE, 32'h0);
		chk("errcode", 32'h7001, rd);
		apb(1'b1, 8'h30, 32'h1);
		chk("slverr", 1'b1, er);
		apb(1'b1, SDEE_OFF_SIO_WORD, 32'hffff_ffff);
		apb(1'b0, SDEE_OFF_SIO_WORD, 32'h0);
		chk("ro word", 32'h2, rd);
		chk("idle off", 16'h0, rx_cnt);
	endtask

	task automatic t_sio();
		logic [31:0] tbl [12];
		tbl = '{32'h2, 32'h4, 32'h8, 32'h10, 32'h20, 32'hf00, 32'hc000,
			32'hff_0000, 32'h5500_0000, 32'haa00_0000, 32'hffff_ffff, 32'h30c1};
		apb(1'b1, SDEE_OFF_MODIDX, 32'h95);
		apb(1'b1, SDEE_OFF_ERRCODE, 32'h005a_7001);
		apb(1'b1, SDEE_OFF_CTRL, 32'h2301);
		foreach (tbl[i]) begin
			sw <= tbl[i];
			frame(tbl[i] & 32'hffff_cf3e, SDEE_ID_SIO, 4'h5);
		end
	endtask

	task automatic t_gw();
		logic [31:0] tbl [6];
		tbl = '{32'h2, 32'h10, 32'h20, 32'h40, 32'hffff_ffff, 32'h8d};
		stall <= 4'h3;
		foreach (tbl[i]) begin
			gw <= tbl[i];
			frame(tbl[i] & 32'h72, SDEE_ID_GW, 4'h9);
		end
	endtask

	// Both change at once, safe changes again while busy
	task automatic t_busy();
		stall <= 4'h8;
		apb(1'b1, SDEE_OFF_IRQ_STAT, 32'hf);
		sw <= 32'h2;
		gw <= 32'h2;
		repeat (4) @(posedge pclk);
		apb(1'b0, SDEE_OFF_STATUS, 32'h0);
		chk("status busy", 32'h5, rd);
		sw <= 32'h4;
		frame(32'h2, SDEE_ID_SIO, 4'h5);
		frame(32'h4, SDEE_ID_SIO, 4'h5);
		frame(32'h2, SDEE_ID_GW, 4'h9);
		apb(1'b0, SDEE_OFF_IRQ_STAT, 32'h0);
		chk("overrun", 4'hf, rd[3:0]);
	endtask

	task automatic t_irq();
		stall <= 4'h0;
		apb(1'b1, SDEE_OFF_IRQ_STAT, 32'hf);
		apb(1'b1, SDEE_OFF_IRQ_MASK, 32'h1);
		sw <= 32'h8;
		frame(32'h8, SDEE_ID_SIO, 4'h5);
		apb(1'b0, SDEE_OFF_IRQ_STAT, 32'h0);
		chk("irq stat", 4'h3, rd[3:0]);
		chk("irq on", 1'b1, irq);
		apb(1'b1, SDEE_OFF_IRQ_MASK, 32'h0);
		@(posedge pclk);
		chk("irq masked", 1'b0, irq);
		apb(1'b1, SDEE_OFF_IRQ_STAT, 32'h3);
		apb(1'b0, SDEE_OFF_IRQ_STAT, 32'h0);
		chk("irq cleared", 4'h0, rd[3:0]);
		apb(1'b0, SDEE_OFF_LAST, 32'h0);
		chk("last", 32'h8, rd);
	endtask

	task automatic t_force();
		apb(1'b1, SDEE_OFF_CTRL, 32'h2303);
		frame(32'h8, SDEE_ID_SIO, 4'h5);
		apb(1'b0, SDEE_OFF_CTRL, 32'h0);
		chk("ctrl", 32'h2301, rd);
		apb(1'b0, SDEE_OFF_COUNT, 32'h0);
		chk("count", nfr, rd[15:0]);
	endtask

	// Reset for six cycles, then the scenarios
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_sio();
		t_gw();
		t_busy();
		t_irq();
		t_force();
		stop_test();
	end
endmodule
